// ==== src/lcn_pkg.sv ====
// constants, source codes and types shared by the local clock network selector
package lcn_pkg;

  // ==========================================================================
  // network sizes
  localparam int GLOBAL_W          = 32;   // global network signals
  localparam int REMOTE_W          = 16;   // signals from fabric in another region
  localparam int LOCAL_SLOTS       = 16;   // feeding signals per local network
  localparam int REGIONAL_W_EDGE   = 8;    // regional signals in top/bottom regions
  localparam int REGIONAL_W_CORE   = 4;    // regional signals in all other regions
  localparam int REGIONAL_W_MAX    = 8;
  localparam int LOCAL_FAB_W_DEF   = 20;   // local fabric clock or control sources
  localparam int REGION_CELLS      = 80;   // logic cells per column per core region
  localparam int NET_CELLS         = 40;   // logic cells covered by one local network
  localparam int NETS_PER_COLUMN   = 4;    // lower half, upper half, multiplier, memory
  localparam int EDGE_GLOBAL_SLOTS = 14;   // top/bottom slots fed from the tree
  localparam int EDGE_FABRIC_SLOTS = 2;    // top/bottom slots fed from fabric
  localparam int SIDE_SLOTS        = 4;    // left/right interface clocks
  localparam int SIDE_FABRIC_MAX   = 2;    // left/right clocks that may come from fabric

  // ==========================================================================
  // source code: class in bits 6:5, index in bits 4:0
  localparam int          SRC_W          = 7;
  localparam int          SRC_IDX_W      = 5;
  localparam logic [1:0]  SRC_GLOBAL     = 2'h0;
  localparam logic [1:0]  SRC_REMOTE     = 2'h1;
  localparam logic [1:0]  SRC_REGIONAL   = 2'h2;
  localparam logic [1:0]  SRC_LOCAL      = 2'h3;
  localparam logic [4:0]  PLL_FIFTH_IDX  = 5'h1f;  // local class, edge regions only
  localparam logic [6:0]  SRC_RESET      = 7'h00;

  // ==========================================================================
  // net roles inside a column
  localparam int NET_ROLE_LOWER = 0;
  localparam int NET_ROLE_UPPER = 1;
  localparam int NET_ROLE_MULT  = 2;
  localparam int NET_ROLE_MEM   = 3;

  typedef enum logic [1:0]
  {
    REGION_CORE = 2'h1,   // core logic plus a left or right interface net
    REGION_EDGE = 2'h2    // top or bottom interface region only
  } region_kind_type;

  typedef enum logic [1:0]
  {
    CFG_OPEN = 2'h1,
    CFG_RUN  = 2'h2
  } cfg_state_type;

endpackage : lcn_pkg

// ==== src/net_enable_gate.sv ====
// glitch-free enable gate for one local network
module net_enable_gate
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] src_in,
  output logic      [WIDTH-1:0] gated_out
);

  logic             en_ff;
  logic [WIDTH-1:0] out_ff;

  // ==========================================================================
  // enable capture
  // enable only moves on an edge, so the gate never chops a level mid-cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      en_ff <= 1'b0;
    else
      en_ff <= enable;
  end

  // registered output: a stopped tree holds low, never a runt pulse
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      out_ff <= '0;
    else if (en_ff)
      out_ff <= src_in;
    else
      out_ff <= '0;
  end

  assign gated_out = out_ff;

endmodule : net_enable_gate

// ==== src/local_clock_network_select.sv ====
// local clock network source selection and distribution for one region
module local_clock_network_select
  import lcn_pkg::*;
#(
  parameter int              COLUMNS     = 4,
  parameter region_kind_type REGION_KIND = REGION_CORE,
  parameter int              LOCAL_FAB_W = LOCAL_FAB_W_DEF
)
(
  input  wire logic                                       sys_clk,
  input  wire logic                                       reset,
  input  wire logic [lcn_pkg::GLOBAL_W-1:0]               global_net,
  input  wire logic [lcn_pkg::REMOTE_W-1:0]               remote_fabric,
  input  wire logic [lcn_pkg::REGIONAL_W_MAX-1:0]         regional_net,
  input  wire logic [LOCAL_FAB_W-1:0]                     local_fabric,
  input  wire logic                                       pll_fifth_output,
  input  wire logic                                       cfg_we,
  input  wire logic [7:0]                                 cfg_net,
  input  wire logic [3:0]                                 cfg_slot,
  input  wire logic [lcn_pkg::SRC_W-1:0]                  cfg_src,
  input  wire logic                                       cfg_done,
  input  wire logic [COLUMNS*lcn_pkg::NETS_PER_COLUMN:0]  net_enable,
  input  wire logic [COLUMNS*lcn_pkg::REGION_CELLS-1:0]   cell_ce_fabric,
  output logic      [COLUMNS*lcn_pkg::NETS_PER_COLUMN*lcn_pkg::LOCAL_SLOTS-1:0] core_net,
  output logic      [lcn_pkg::LOCAL_SLOTS-1:0]            iface_clk,
  output logic      [COLUMNS*lcn_pkg::REGION_CELLS-1:0]   logic_cell_ce,
  output logic                                            cfg_locked,
  output logic                                            cfg_reject
);

  import lcn_pkg::*;

  // ==========================================================================
  // timing at a glance
  // a write taken on edge k fills its slot at edge k; the mux sees it at once
  // the gate captures the mux one edge later, so a source shows after one edge
  // net_enable is captured first, so an enable change shows on a net after two edges, on cell enables after one
  // a refused write leaves the slot alone and pulses cfg_reject for a cycle
  // cfg_done in the open state freezes the table at the next edge
  // a write on the same edge as cfg_done still lands, the state is still open
  // only reset reopens the table, and reset also empties every slot
  //
  // source code layout
  // class 0 picks a global signal, any of the 32
  // class 1 picks fabric of another region, index below 16
  // class 2 picks a regional signal, index below 4 or 8 by region kind
  // class 3 picks local fabric, or the fifth pll output at index 31 on an edge
  //
  // net numbering
  // net col*4+0 lower cells, +1 upper cells, +2 multiplier, +3 memory
  // the last net faces the interface blocks of this region
  // edge regions keep every core net dark and only use the interface net

  // ==========================================================================
  // derived sizes
  localparam bit EDGE      = (REGION_KIND == REGION_EDGE);
  localparam int REG_W     = EDGE ? REGIONAL_W_EDGE : REGIONAL_W_CORE;
  localparam int CORE_NETS = COLUMNS * NETS_PER_COLUMN;
  localparam int NETS      = CORE_NETS + 1;   // last net faces the interface blocks
  localparam int IFACE_NET = NETS - 1;

  cfg_state_type                  cfg_state_ff;
  logic [SRC_W-1:0]               sel_ff   [NETS][LOCAL_SLOTS];
  logic                           used_ff  [NETS][LOCAL_SLOTS];
  logic                           reject_ff;
  logic [COLUMNS*REGION_CELLS-1:0] cell_ce_ff;
  logic [LOCAL_SLOTS-1:0]         raw_net  [NETS];
  logic [LOCAL_SLOTS-1:0]         gated_net[NETS];
  logic                           wr_ok;
  logic                           dup_hit;

  // ==========================================================================
  // source legality per network and slot
  // one function holds the legality rules used by the write check,
  // so the slot limits live in exactly one place
  // out-of-range nets and slots fall out first, before the class tests
  // the side interface net limits fabric by slot position, not by counting,
  // which costs two slots of flexibility but needs no counter
  function automatic logic src_legal(input int net, input int slot, input logic [SRC_W-1:0] src);
    logic [1:0] cls;
    int         idx;
    logic       tree;
    logic       fabric;
    cls    = src[SRC_W-1:SRC_IDX_W];
    idx    = int'(src[SRC_IDX_W-1:0]);
    tree   = (cls == SRC_GLOBAL) || ((cls == SRC_REGIONAL) && (idx < REG_W));
    fabric = ((cls == SRC_REMOTE) && (idx < REMOTE_W)) ||
             ((cls == SRC_LOCAL) && (idx < LOCAL_FAB_W));
    src_legal = 1'b0;
    if (net >= NETS || slot >= LOCAL_SLOTS)
      src_legal = 1'b0;
    else if (net == IFACE_NET && EDGE)
    begin
      // fourteen tree clocks, then two fabric clocks; fifth pll output only here
      if (slot < EDGE_GLOBAL_SLOTS)
        src_legal = tree || ((cls == SRC_LOCAL) && (idx == int'(PLL_FIFTH_IDX)));
      else
        src_legal = fabric;
    end
    else if (net == IFACE_NET)
    begin
      // fabric clocks confined to the first two slots keeps the limit structural
      if (slot >= SIDE_SLOTS)
        src_legal = 1'b0;
      else if (slot < SIDE_FABRIC_MAX)
        src_legal = tree || fabric;
      else
        src_legal = tree;
    end
    else
      src_legal = !EDGE && (tree || fabric);
  endfunction : src_legal

  // value of the signal named by a source code
  // an index past the end of its class reads low instead of wrapping,
  // so a stale code can never alias onto a neighbouring source
  // the fifth pll output shadows local index 31 only in edge regions
  function automatic logic pick(input logic [SRC_W-1:0] src);
    logic [1:0] cls;
    int         idx;
    cls  = src[SRC_W-1:SRC_IDX_W];
    idx  = int'(src[SRC_IDX_W-1:0]);
    pick = 1'b0;
    unique case (cls)
      SRC_GLOBAL:   pick = global_net[idx];
      SRC_REMOTE:   pick = (idx < REMOTE_W) ? remote_fabric[idx] : 1'b0;
      SRC_REGIONAL: pick = (idx < REG_W) ? regional_net[idx] : 1'b0;
      SRC_LOCAL:
      begin
        if (EDGE && idx == int'(PLL_FIFTH_IDX))
          pick = pll_fifth_output;
        else if (idx < LOCAL_FAB_W)
          pick = local_fabric[idx];
        else
          pick = 1'b0;
      end
    endcase
  endfunction : pick

  // local network covering a logic cell row of a column
  function automatic int cell_net(input int column, input int row);
    cell_net = column * NETS_PER_COLUMN + ((row < NET_CELLS) ? NET_ROLE_LOWER : NET_ROLE_UPPER);
  endfunction : cell_net

  // ==========================================================================
  // configuration write check
  // a source already held by another slot of the same net would waste a feed
  always_comb
  begin
    dup_hit = 1'b0;
    if (int'(cfg_net) < NETS)
    begin
      for (int s = 0; s < LOCAL_SLOTS; s++)
      begin
        if (used_ff[int'(cfg_net)][s] && s != int'(cfg_slot) && sel_ff[int'(cfg_net)][s] == cfg_src)
          dup_hit = 1'b1;
      end
    end
    wr_ok = cfg_we && (cfg_state_ff == CFG_OPEN) && !dup_hit &&
            src_legal(int'(cfg_net), int'(cfg_slot), cfg_src);
  end

  // configuration state: open until done, then frozen until reset
  // there is no way back to open short of reset, by intent: a live table
  // edit could switch a running clock mid-pulse
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      cfg_state_ff <= CFG_OPEN;
    else
    begin
      unique case (cfg_state_ff)
        CFG_OPEN: if (cfg_done) cfg_state_ff <= CFG_RUN;
        CFG_RUN:  cfg_state_ff <= CFG_RUN;
        default:  cfg_state_ff <= CFG_OPEN;
      endcase
    end
  end

  // selection storage; writes after lock never land
  // the used flag separates an empty slot from one holding code zero,
  // since code zero is a legal global source
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (int n = 0; n < NETS; n++)
      begin
        for (int s = 0; s < LOCAL_SLOTS; s++)
        begin
          sel_ff[n][s]  <= SRC_RESET;
          used_ff[n][s] <= 1'b0;
        end
      end
    end
    else if (wr_ok)
    begin
      sel_ff[int'(cfg_net)][int'(cfg_slot)]  <= cfg_src;
      used_ff[int'(cfg_net)][int'(cfg_slot)] <= 1'b1;
    end
  end

  // one-cycle refusal pulse for a write that was not taken
  // back-to-back writes give back-to-back answers, one per write
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      reject_ff <= 1'b0;
    else
      reject_ff <= cfg_we && !wr_ok;
  end

  // ==========================================================================
  // source multiplexers: sixteen feeds per net, empty slots stay low
  // every slot has its own full mux, so any slot may take any legal code
  // area grows with nets times slots; acceptable for a static table
  always_comb
  begin
    for (int n = 0; n < NETS; n++)
    begin
      for (int s = 0; s < LOCAL_SLOTS; s++)
        raw_net[n][s] = used_ff[n][s] && pick(sel_ff[n][s]);
    end
  end

  // per-net enable gates
  // one gate per net, including the interface net, so each tree can sleep
  // on its own without disturbing its neighbours
  generate
    for (genvar n = 0; n < NETS; n++)
    begin : g_gate
      net_enable_gate
      #(
        .WIDTH     (LOCAL_SLOTS)
      )
      u_gate
      (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .enable    (net_enable[n]),
        .src_in    (raw_net[n]),
        .gated_out (gated_net[n])
      );
    end
  endgenerate

  // ==========================================================================
  // distribution
  // core nets: lower half, upper half, multiplier and memory per column
  // an edge region forces these low even if its gates would pass something
  always_comb
  begin
    for (int n = 0; n < CORE_NETS; n++)
      core_net[n*LOCAL_SLOTS +: LOCAL_SLOTS] = EDGE ? '0 : gated_net[n];
  end

  // interface clocks leave the tree directly, not through the fabric outputs
  assign iface_clk = gated_net[IFACE_NET];

  // per-cell clock enable straight from fabric, held off while its net sleeps
  // each cell keeps its own enable; only the half-column net gates it
  // the enable is registered, so it trails the fabric by one edge
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      cell_ce_ff <= '0;
    else
    begin
      for (int c = 0; c < COLUMNS; c++)
      begin
        for (int r = 0; r < REGION_CELLS; r++)
          cell_ce_ff[c*REGION_CELLS+r] <= !EDGE && cell_ce_fabric[c*REGION_CELLS+r] &&
                                          net_enable[cell_net(c, r)];
      end
    end
  end

  assign logic_cell_ce = cell_ce_ff;
  assign cfg_locked    = (cfg_state_ff == CFG_RUN);
  assign cfg_reject    = reject_ff;

endmodule : local_clock_network_select

// ==== sim/lcn_select_properties.sv ====
// port assertions for the local clock network selector
module lcn_select_properties
  import lcn_pkg::*;
#(
  parameter int COLUMNS   = 4,
  parameter bit EDGE_KIND = 1'b0
)
(
  input wire logic                                               sys_clk,
  input wire logic                                               reset,
  input wire logic                                               cfg_we,
  input wire logic [7:0]                                         cfg_net,
  input wire logic [3:0]                                         cfg_slot,
  input wire logic                                               cfg_done,
  input wire logic                                               cfg_locked,
  input wire logic                                               cfg_reject,
  input wire logic [COLUMNS*lcn_pkg::NETS_PER_COLUMN:0]          net_enable,
  input wire logic [COLUMNS*lcn_pkg::REGION_CELLS-1:0]           cell_ce_fabric,
  input wire logic [COLUMNS*lcn_pkg::REGION_CELLS-1:0]           logic_cell_ce,
  input wire logic [COLUMNS*lcn_pkg::NETS_PER_COLUMN*16-1:0]     core_net,
  input wire logic [lcn_pkg::LOCAL_SLOTS-1:0]                    iface_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  lock_entry_a: assert property (!cfg_locked && cfg_done |=> cfg_locked) else $error("lock missed");
  lock_holds_a: assert property (cfg_locked |=> cfg_locked) else $error("lock dropped");
  late_write_a: assert property (cfg_locked && cfg_we |=> cfg_reject) else $error("late write taken");
  quiet_reject_a: assert property (!cfg_we |=> !cfg_reject) else $error("spurious reject");
  net_range_a: assert property (cfg_we && cfg_net > COLUMNS*4 |=> cfg_reject) else $error("bad net taken");
  side_slot_a: assert property (!EDGE_KIND && cfg_we && cfg_net == COLUMNS*4 && cfg_slot > 4'h3 |=> cfg_reject)
    else $error("side slot taken");
  side_quiet_a: assert property (EDGE_KIND || iface_clk[15:4] == 12'h000) else $error("unused side slot active");
  net_off_a: assert property (!net_enable[0] |=> ##1 core_net[15:0] == 16'h0000) else $error("net not gated");
  cell_on_a: assert property (!EDGE_KIND && net_enable[0] && cell_ce_fabric[0] |=> logic_cell_ce[0])
    else $error("cell enable lost");
  upper_off_a: assert property (!net_enable[1] |=> !logic_cell_ce[40] && !logic_cell_ce[79])
    else $error("upper half not gated");
endmodule : lcn_select_properties

bind local_clock_network_select lcn_select_properties #(.COLUMNS(COLUMNS), .EDGE_KIND(REGION_KIND == REGION_EDGE))
  props_u (.sys_clk, .reset, .cfg_we,
  .cfg_net, .cfg_slot, .cfg_done, .cfg_locked, .cfg_reject, .net_enable, .cell_ce_fabric, .logic_cell_ce,
  .core_net, .iface_clk);

// ==== sim/fabric_side_model.sv ====
// fabric-side model: local clock sources and per-cell enables
module fabric_side_model
#(
  parameter int CELLS = 80,
  parameter int FAB_W = 20
)
(
  input  wire logic             ce_mode,
  output logic      [FAB_W-1:0] local_fabric,
  output logic      [CELLS-1:0] cell_ce_fabric
);
  timeunit 1ns;
  timeprecision 1ps;
  // only the top source is high, so a wrong index reads low
  assign local_fabric = {1'b1, {(FAB_W-1){1'b0}}};
  // neighbours differ so a shared enable would show
  assign cell_ce_fabric = ce_mode ? {(CELLS/2){2'b10}} : {(CELLS/2){2'b01}};
endmodule : fabric_side_model

// ==== sim/local_clock_network_select_tb_top.sv ====
// self-checking bench for the local clock network selector
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module local_clock_network_select_tb_top;
  import lcn_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] net; logic [3:0] slot; logic [6:0] src; logic rej;} row_type;
  logic        sys_clk, reset, pll_fifth_output, cfg_we, cfg_done, cfg_locked, cfg_reject, ce_mode;
  logic [31:0] global_net = 32'h8000_02a0;
  logic [15:0] remote_fabric = 16'h8004;
  logic [7:0]  regional_net = 8'h08;
  logic [19:0] local_fabric;
  logic [7:0]  cfg_net;
  logic [3:0]  cfg_slot;
  logic [6:0]  cfg_src;
  logic [4:0]  net_enable;
  logic [79:0] cell_ce_fabric, logic_cell_ce;
  logic [63:0] core_net;
  logic [15:0] iface_clk;
  logic [79:0] all_nets;
  int          fail_count = 0;
  int          samples_checked = 0;
  row_type     rows [16] = '{'{8'h00, 4'h0, 7'h05, 1'b0}, '{8'h00, 4'h1, 7'h1f, 1'b0}, '{8'h01, 4'h0, 7'h2f, 1'b0},
    '{8'h01, 4'h1, 7'h30, 1'b1}, '{8'h02, 4'h0, 7'h43, 1'b0}, '{8'h02, 4'h1, 7'h44, 1'b1},
    '{8'h03, 4'h0, 7'h73, 1'b0}, '{8'h03, 4'h1, 7'h74, 1'b1}, '{8'h00, 4'h2, 7'h05, 1'b1},
    '{8'h00, 4'hf, 7'h07, 1'b0}, '{8'h04, 4'h0, 7'h22, 1'b0}, '{8'h04, 4'h2, 7'h23, 1'b1},
    '{8'h04, 4'h3, 7'h09, 1'b0}, '{8'h04, 4'h4, 7'h0a, 1'b1}, '{8'h05, 4'h0, 7'h05, 1'b1},
    '{8'h03, 4'h2, 7'h7f, 1'b1}};

  local_clock_network_select #(.COLUMNS(1), .REGION_KIND(REGION_CORE), .LOCAL_FAB_W(20)) dut_u (.sys_clk, .reset,
    .global_net, .remote_fabric, .regional_net, .local_fabric, .pll_fifth_output, .cfg_we, .cfg_net, .cfg_slot,
    .cfg_src, .cfg_done, .net_enable, .cell_ce_fabric, .core_net, .iface_clk, .logic_cell_ce, .cfg_locked,
    .cfg_reject);
  fabric_side_model #(.CELLS(80), .FAB_W(20)) model_u (.ce_mode, .local_fabric, .cell_ce_fabric);
  // interface net sits above the core nets, net n at bits n*16+:16
  assign all_nets = {iface_clk, core_net};

  // ==========================================================================
  // helpers
  function automatic logic level_of(input logic [6:0] src);
    case (src[6:5])
      2'h0: level_of = global_net[src[4:0]];
      2'h1: level_of = remote_fabric[src[3:0]];
      2'h2: level_of = regional_net[src[2:0]];
      default: level_of = local_fabric[src[4:0]];
    endcase
  endfunction : level_of

  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // free-running 50 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // main sequence: table of writes first, then the awkward cases
  initial
  begin
    {reset, pll_fifth_output, cfg_we, cfg_done, ce_mode} = 5'b11000;
    {cfg_net, cfg_slot, cfg_src} = 19'h0;
    net_enable = 5'h1f;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("reset state", 82'h0, {cfg_locked, cfg_reject, core_net, iface_clk})
    reset = 1'b0;
    foreach (rows[i])
    begin
      {cfg_we, cfg_net, cfg_slot, cfg_src} = {1'b1, rows[i].net, rows[i].slot, rows[i].src};
      @(posedge sys_clk);
      #1 `CHK("reject", rows[i].rej, cfg_reject)
    end
    cfg_we = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    foreach (rows[i])
      if (rows[i].net < 8'h05)
        `CHK("net level", rows[i].rej ? 1'b0 : level_of(rows[i].src),
          all_nets[rows[i].net * 16 + rows[i].slot])
    net_enable[0] = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("net off", 16'h0000, core_net[15:0])
    net_enable[0] = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("net on", 16'h8003, core_net[15:0])
    net_enable[1] = 1'b0;
    @(posedge sys_clk);
    #1 `CHK("cell enables", {40'h0, {20{2'b01}}}, logic_cell_ce)
    {ce_mode, net_enable[1]} = 2'b11;
    @(posedge sys_clk);
    #1 `CHK("cell enables", {40{2'b10}}, logic_cell_ce)
    {cfg_done, cfg_we, cfg_net, cfg_slot, cfg_src} = {2'b11, 8'h00, 4'h3, 7'h09};
    @(posedge sys_clk);
    #1 `CHK("write at lock", 1'b0, cfg_reject)
    {cfg_done, cfg_slot, cfg_src} = {1'b0, 4'h4, 7'h2f};
    for (int n = 0; n < 4 && cfg_locked !== 1'b1; n++)
      @(posedge sys_clk);
    if (cfg_locked !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
    @(posedge sys_clk);
    #1 `CHK("write after lock", 1'b1, cfg_reject)
    cfg_we = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("frozen net", 16'h800b, core_net[15:0])
    reset = 1'b1;
    @(posedge sys_clk);
    #1 `CHK("lock cleared", 65'h0, {cfg_locked, core_net})
    reset = 1'b0;
    close_out();
  end
endmodule : local_clock_network_select_tb_top
